/* File: rtl/isa_decode_pkg.sv */
// Constants for the ISA window and alias decoder
package isa_decode_pkg;
  localparam int IO_AW = 16;
  localparam int MEM_AW = 24;
  localparam int NUM_IO_WIN = 4;
  localparam int NUM_MEM_WIN = 2;
  localparam int NUM_DMA_CH = 8;
  localparam int DMA_NO_BLOCK_CH = 4;
  localparam int ALIAS_LOW_BITS = 10;
  localparam logic [15:0] DMA_BLOCK_BASE = 16'h2000;
  localparam logic [15:0] DMA_BLOCK_STRIDE = 16'h0100;
  localparam int DMA_BLOCK_SIZE_BITS = 4;
  localparam logic [15:0] PCI_IO_FLOOR = 16'h1000;
  localparam int REG_AW = 8;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DMA_EN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IO_BASE0 = 8'h10;
  localparam logic [7:0] REG_IO_LIM0 = 8'h14;
  localparam logic [7:0] REG_MEM_BASE0 = 8'h40;
  localparam logic [7:0] REG_MEM_LIM0 = 8'h44;
  localparam logic [7:0] REG_WIN_STRIDE = 8'h08;
  // CTRL fields
  localparam int CTRL_ALIAS_BIT = 0;
  localparam int CTRL_IOWIN_LSB = 8;
  localparam int CTRL_MEMWIN_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [7:0] DMA_EN_RESET = 8'h00;
  // STATUS fields
  localparam int ST_FWD_BIT = 0;
  localparam int ST_DMA_BIT = 1;
  localparam int ST_ALIAS_BIT = 2;
  localparam int ST_PCI_BIT = 3;
endpackage

/* File: rtl/io_window_match.sv */
// One I/O window compare, exact or 10-bit aliased
`timescale 1ns/1ps
`default_nettype none
module io_window_match
  import isa_decode_pkg::*;
(
  input wire logic [IO_AW-1:0] addr_in,
  input wire logic [IO_AW-1:0] base_in,
  input wire logic [IO_AW-1:0] limit_in,
  input wire logic enable_in,
  input wire logic alias_in,
  output logic exact_out,
  output logic hit_out
);
  logic [IO_AW-1:0] folded;
  always_comb begin
    // Upper bits of the window are kept so the alias lands in the window's own 1K page
    folded = {base_in[IO_AW-1:ALIAS_LOW_BITS], addr_in[ALIAS_LOW_BITS-1:0]};
    exact_out = enable_in && (addr_in >= base_in) && (addr_in <= limit_in);
    hit_out = exact_out || (enable_in && alias_in && (folded >= base_in) && (folded <= limit_in));
  end
endmodule // io_window_match
`default_nettype wire

/* File: rtl/isa_window_alias_decoder.sv */
// Positive decode of host cycles onto the ISA bus, with alias and DMA channel gating
`timescale 1ns/1ps
`default_nettype none
module isa_window_alias_decoder
  import isa_decode_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic host_valid_in,
  input wire logic host_is_io_in,
  input wire logic [31:0] host_addr_in,
  input wire logic [NUM_DMA_CH-1:0] dma_req_in,
  output logic isa_fwd_out,
  output logic alias_hit_out,
  output logic dma_block_hit_out,
  output logic [2:0] dma_block_ch_out,
  output logic pci_region_out,
  output logic [NUM_DMA_CH-1:0] dma_service_out
);
  logic alias_en_ff;
  logic [NUM_IO_WIN-1:0] io_en_ff;
  logic [NUM_MEM_WIN-1:0] mem_en_ff;
  logic [NUM_DMA_CH-1:0] dma_en_ff;
  logic [IO_AW-1:0] io_base_ff [NUM_IO_WIN];
  logic [IO_AW-1:0] io_lim_ff [NUM_IO_WIN];
  logic [MEM_AW-1:0] mem_base_ff [NUM_MEM_WIN];
  logic [MEM_AW-1:0] mem_lim_ff [NUM_MEM_WIN];
  logic fwd_ff;
  logic alias_hit_ff;
  logic blk_hit_ff;
  logic [2:0] blk_ch_ff;
  logic pci_ff;
  logic [NUM_DMA_CH-1:0] dma_srv_ff;
  logic [31:0] rdata_ff;
  logic [NUM_IO_WIN-1:0] io_exact;
  logic [NUM_IO_WIN-1:0] io_hit;
  logic [NUM_MEM_WIN-1:0] mem_hit;
  logic [IO_AW-1:0] io_addr;
  logic [MEM_AW-1:0] mem_addr;
  logic nxt_blk_hit;
  logic [2:0] nxt_blk_ch;
  logic [31:0] nxt_rdata;
  logic cycle_io;
  logic cycle_mem;

  assign io_addr = host_addr_in[IO_AW-1:0];
  assign mem_addr = host_addr_in[MEM_AW-1:0];
  assign cycle_io = host_valid_in && host_is_io_in;
  assign cycle_mem = host_valid_in && !host_is_io_in;

  // Window compares, one per window
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO_WIN; gi++) begin : g_io
      io_window_match u_match (
        .addr_in(io_addr),
        .base_in(io_base_ff[gi]),
        .limit_in(io_lim_ff[gi]),
        .enable_in(io_en_ff[gi]),
        .alias_in(alias_en_ff),
        .exact_out(io_exact[gi]),
        .hit_out(io_hit[gi])
      );
    end
    for (gi = 0; gi < NUM_MEM_WIN; gi++) begin : g_mem
      // Upper host address bits must be zero: ISA memory lives below 16 MB
      assign mem_hit[gi] = mem_en_ff[gi] && (host_addr_in[31:MEM_AW] == '0)
        && (mem_addr >= mem_base_ff[gi]) && (mem_addr <= mem_lim_ff[gi]);
    end
  endgenerate

  // Distributed DMA slave block decode
  always_comb begin
    nxt_blk_hit = 1'b0;
    nxt_blk_ch = io_addr[10:8];
    if (cycle_io && (io_addr[15:11] == DMA_BLOCK_BASE[15:11])
        && (io_addr[7:DMA_BLOCK_SIZE_BITS] == '0)
        && (io_addr[10:8] != 3'(DMA_NO_BLOCK_CH))) begin
      nxt_blk_hit = dma_en_ff[io_addr[10:8]];
    end
  end

  // Configuration registers
  // A host cycle in the same clock as a CTRL write still decodes with the old enables
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      alias_en_ff <= CTRL_RESET[CTRL_ALIAS_BIT];
      io_en_ff <= '0;
      mem_en_ff <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      alias_en_ff <= reg_wdata_in[CTRL_ALIAS_BIT];
      io_en_ff <= reg_wdata_in[CTRL_IOWIN_LSB +: NUM_IO_WIN];
      mem_en_ff <= reg_wdata_in[CTRL_MEMWIN_LSB +: NUM_MEM_WIN];
    end
  end

  // Channel 4 has no slave block, so its enable is held at zero whatever is written
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      dma_en_ff <= DMA_EN_RESET;
    end else if (reg_wr_in && reg_addr_in == REG_DMA_EN) begin
      dma_en_ff <= reg_wdata_in[NUM_DMA_CH-1:0];
      dma_en_ff[DMA_NO_BLOCK_CH] <= 1'b0;
    end
  end

  // Base and limit are inclusive; a window with its base above its limit never hits
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < NUM_IO_WIN; i++) begin
      if (rst_in) begin
        io_base_ff[i] <= '0;
        io_lim_ff[i] <= '0;
      end else if (reg_wr_in && reg_addr_in == REG_IO_BASE0 + 8'(i) * REG_WIN_STRIDE) begin
        io_base_ff[i] <= reg_wdata_in[IO_AW-1:0];
      end else if (reg_wr_in && reg_addr_in == REG_IO_LIM0 + 8'(i) * REG_WIN_STRIDE) begin
        io_lim_ff[i] <= reg_wdata_in[IO_AW-1:0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    for (int i = 0; i < NUM_MEM_WIN; i++) begin
      if (rst_in) begin
        mem_base_ff[i] <= '0;
        mem_lim_ff[i] <= '0;
      end else if (reg_wr_in && reg_addr_in == REG_MEM_BASE0 + 8'(i) * REG_WIN_STRIDE) begin
        mem_base_ff[i] <= reg_wdata_in[MEM_AW-1:0];
      end else if (reg_wr_in && reg_addr_in == REG_MEM_LIM0 + 8'(i) * REG_WIN_STRIDE) begin
        mem_lim_ff[i] <= reg_wdata_in[MEM_AW-1:0];
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr_in == REG_CTRL) begin
      nxt_rdata[CTRL_ALIAS_BIT] = alias_en_ff;
      nxt_rdata[CTRL_IOWIN_LSB +: NUM_IO_WIN] = io_en_ff;
      nxt_rdata[CTRL_MEMWIN_LSB +: NUM_MEM_WIN] = mem_en_ff;
    end else if (reg_addr_in == REG_DMA_EN) begin
      nxt_rdata[NUM_DMA_CH-1:0] = dma_en_ff;
    end else if (reg_addr_in == REG_STATUS) begin
      nxt_rdata[ST_FWD_BIT] = fwd_ff;
      nxt_rdata[ST_DMA_BIT] = blk_hit_ff;
      nxt_rdata[ST_ALIAS_BIT] = alias_hit_ff;
      nxt_rdata[ST_PCI_BIT] = pci_ff;
    end
    for (int i = 0; i < NUM_IO_WIN; i++) begin
      if (reg_addr_in == REG_IO_BASE0 + 8'(i) * REG_WIN_STRIDE) nxt_rdata[IO_AW-1:0] = io_base_ff[i];
      if (reg_addr_in == REG_IO_LIM0 + 8'(i) * REG_WIN_STRIDE) nxt_rdata[IO_AW-1:0] = io_lim_ff[i];
    end
    for (int i = 0; i < NUM_MEM_WIN; i++) begin
      if (reg_addr_in == REG_MEM_BASE0 + 8'(i) * REG_WIN_STRIDE) nxt_rdata[MEM_AW-1:0] = mem_base_ff[i];
      if (reg_addr_in == REG_MEM_LIM0 + 8'(i) * REG_WIN_STRIDE) nxt_rdata[MEM_AW-1:0] = mem_lim_ff[i];
    end
  end

  // Read data is valid only in the cycle after the strobe
  // Zero outside that cycle, so a master that samples late never sees stale data
  always_ff @(posedge clock_in) begin
    if (rst_in || !reg_rd_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Decode results, registered one cycle behind the host cycle
  // A window overlapping onboard PCI space is still forwarded; only the flag warns software
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fwd_ff <= 1'b0;
      alias_hit_ff <= 1'b0;
      pci_ff <= 1'b0;
    end else begin
      fwd_ff <= (cycle_io && |io_hit) || (cycle_mem && |mem_hit);
      alias_hit_ff <= cycle_io && |io_hit && !(|io_exact);
      // Flags onboard PCI space so a window reaching into it is visible to software
      pci_ff <= cycle_io && (io_addr >= PCI_IO_FLOOR) && !nxt_blk_hit;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      blk_hit_ff <= 1'b0;
      blk_ch_ff <= '0;
      dma_srv_ff <= '0;
    end else begin
      blk_hit_ff <= nxt_blk_hit;
      blk_ch_ff <= nxt_blk_ch;
      dma_srv_ff <= dma_req_in & dma_en_ff;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign isa_fwd_out = fwd_ff;
  assign alias_hit_out = alias_hit_ff;
  assign dma_block_hit_out = blk_hit_ff;
  assign dma_block_ch_out = blk_ch_ff;
  assign pci_region_out = pci_ff;
  assign dma_service_out = dma_srv_ff;

  chk_fwd_needs_window: assert property (@(posedge clock_in) disable iff (rst_in)
    isa_fwd_out |-> $past(host_valid_in) && ($past(|io_hit) || $past(|mem_hit)))
    else $error("forward without an enabled window");
  chk_no_fwd_idle: assert property (@(posedge clock_in) disable iff (rst_in)
    !host_valid_in |=> !isa_fwd_out)
    else $error("forward with no host cycle");
  chk_alias_off_exact: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_io && !alias_en_ff) |=> !alias_hit_out)
    else $error("alias claimed while aliasing disabled");
  chk_alias_claims: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_io && alias_en_ff && io_en_ff[0] && io_base_ff[0] <= io_lim_ff[0]
     && {io_base_ff[0][15:10], io_addr[9:0]} >= io_base_ff[0]
     && {io_base_ff[0][15:10], io_addr[9:0]} <= io_lim_ff[0]) |=> isa_fwd_out)
    else $error("alias of enabled window not claimed");
  chk_alias_mask: assert property (@(posedge clock_in) disable iff (rst_in)
    alias_hit_out |-> $past(alias_en_ff) && $past(host_is_io_in))
    else $error("alias hit without aliased compare");
  chk_dma_gated: assert property (@(posedge clock_in) disable iff (rst_in)
    dma_service_out != '0 |-> (($past(dma_req_in) & $past(dma_en_ff)) == dma_service_out))
    else $error("dma serviced on disabled channel");
  chk_dma_block_range: assert property (@(posedge clock_in) disable iff (rst_in)
    dma_block_hit_out |-> $past(io_addr[15:11]) == 5'h04 && $past(io_addr[7:4]) == 4'h0
      && dma_block_ch_out != 3'h4)
    else $error("dma block hit outside its range");
  chk_no_ch4: assert property (@(posedge clock_in) disable iff (rst_in)
    !dma_en_ff[DMA_NO_BLOCK_CH])
    else $error("channel without block enabled");
  chk_read_one_cycle: assert property (@(posedge clock_in) disable iff (rst_in)
    !$past(reg_rd_in) |-> reg_rdata_out == '0)
    else $error("read data outside its cycle");

  // Window 0 stands in for every window, since the windows of each kind are identical copies
  chk_exact_claims: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_io && io_en_ff[0] && io_addr >= io_base_ff[0] && io_addr <= io_lim_ff[0])
      |=> isa_fwd_out && !alias_hit_out)
    else $error("exact window hit not claimed");
  chk_mem_claims: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_mem && mem_en_ff[0] && host_addr_in[31:MEM_AW] == '0
     && mem_addr >= mem_base_ff[0] && mem_addr <= mem_lim_ff[0]) |=> isa_fwd_out)
    else $error("memory window hit not claimed");
  chk_mem_high_miss: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_mem && host_addr_in[31:MEM_AW] != '0) |=> !isa_fwd_out)
    else $error("memory cycle above 16 MB forwarded");
  chk_all_off_miss: assert property (@(posedge clock_in) disable iff (rst_in)
    (io_en_ff == '0 && mem_en_ff == '0) |=> !isa_fwd_out)
    else $error("forward with every window disabled");
  chk_alias_off_miss: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_io && !alias_en_ff && io_exact == '0) |=> !isa_fwd_out)
    else $error("inexact I/O cycle forwarded while aliasing disabled");
  chk_alias_hit_fwd: assert property (@(posedge clock_in) disable iff (rst_in)
    alias_hit_out |-> isa_fwd_out)
    else $error("alias hit not forwarded");
  chk_exact_not_alias: assert property (@(posedge clock_in) disable iff (rst_in)
    alias_hit_out |-> !$past(|io_exact))
    else $error("exact hit reported as alias");
  chk_ctrl_write_visible: assert property (@(posedge clock_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == REG_CTRL) |=> alias_en_ff == $past(reg_wdata_in[CTRL_ALIAS_BIT]))
    else $error("alias setting not taken from the write");

  // Channel gating and slave block decode
  chk_dma_off_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    (dma_service_out & ~$past(dma_en_ff)) == '0)
    else $error("dma serviced on a channel not enabled");
  chk_dma_blk_enabled: assert property (@(posedge clock_in) disable iff (rst_in)
    dma_block_hit_out |-> $past(dma_en_ff[io_addr[10:8]]))
    else $error("dma block claimed for a disabled channel");
  chk_dma_blk_claims: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_io && io_addr[15:11] == 5'h04 && io_addr[7:4] == 4'h0 && io_addr[10:8] != 3'h4
     && dma_en_ff[io_addr[10:8]]) |=> dma_block_hit_out && dma_block_ch_out == $past(io_addr[10:8]))
    else $error("enabled dma block not claimed");
  chk_dma_en_read: assert property (@(posedge clock_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == REG_DMA_EN) |=> !reg_rdata_out[DMA_NO_BLOCK_CH])
    else $error("channel without block reads enabled");
  chk_block_no_pci: assert property (@(posedge clock_in) disable iff (rst_in)
    dma_block_hit_out |-> !pci_region_out)
    else $error("dma block also flagged as pci space");
  chk_pci_floor: assert property (@(posedge clock_in) disable iff (rst_in)
    pci_region_out |-> $past(cycle_io) && $past(io_addr) >= PCI_IO_FLOOR)
    else $error("pci region flagged below its floor");
  chk_pci_flagged: assert property (@(posedge clock_in) disable iff (rst_in)
    (cycle_io && io_addr >= PCI_IO_FLOOR && !nxt_blk_hit) |=> pci_region_out)
    else $error("onboard pci space not flagged");

  // Status read returns the decode that stood in the strobe cycle
  chk_status_copy: assert property (@(posedge clock_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == REG_STATUS)
      |=> reg_rdata_out == {28'h0, $past(pci_ff), $past(alias_hit_ff), $past(blk_hit_ff), $past(fwd_ff)})
    else $error("status read does not copy the decode");
endmodule // isa_window_alias_decoder
`default_nettype wire

/* File: tb/legacy_card_model.sv */
// Legacy ISA card on the expansion bus that compares only the low address bits
`timescale 1ns/1ps
`default_nettype none
module legacy_card_model
  import isa_decode_pkg::*;
#(
  parameter logic [9:0] BASE = 10'h300,
  parameter logic [9:0] LIMIT = 10'h31f
)
(
  input wire logic fwd_in,
  input wire logic io_in,
  input wire logic [IO_AW-1:0] addr_in,
  output logic claim_out
);
  // Upper bits are not decoded, so every 400h alias selects the card too
  assign claim_out = fwd_in && io_in && addr_in[9:0] >= BASE && addr_in[9:0] <= LIMIT;
endmodule // legacy_card_model
`default_nettype wire

/* File: tb/isa_window_alias_decoder_tb.sv */
// Self-checking bench for the ISA window and alias decoder
`timescale 1ns/1ps
`default_nettype none
module isa_window_alias_decoder_tb
  import isa_decode_pkg::*;
;
  typedef struct packed {logic [31:0] ctl; logic io; logic [31:0] a; logic [3:0] e;} row_type;
  localparam logic [31:0] A = 32'h0001_0101;
  localparam logic [31:0] E = 32'h0001_0100;
  localparam logic [31:0] D = 32'h0000_0001;
  // Expected bits: forward, alias, dma block, pci region
  localparam row_type rows [23] = '{
    '{A, 1'h1, 32'h0300, 4'h8}, '{A, 1'h1, 32'h031f, 4'h8}, '{A, 1'h1, 32'h0320, 4'h0},
    '{A, 1'h1, 32'h0700, 4'hc}, '{A, 1'h1, 32'h0b10, 4'hc}, '{A, 1'h1, 32'h0f1f, 4'hc},
    '{A, 1'h1, 32'h1300, 4'hd}, '{A, 1'h1, 32'h0400, 4'h0}, '{A, 1'h0, 32'h000d_0000, 4'h8},
    '{A, 1'h0, 32'h000d_ffff, 4'h8}, '{A, 1'h0, 32'h000e_0000, 4'h0}, '{A, 1'h0, 32'h010d_0000, 4'h0},
    '{A, 1'h1, 32'h2000, 4'h2}, '{A, 1'h1, 32'h2105, 4'h2}, '{A, 1'h1, 32'h250f, 4'h2},
    '{A, 1'h1, 32'h2600, 4'h1}, '{A, 1'h1, 32'h2400, 4'h1}, '{A, 1'h1, 32'h2510, 4'h1},
    '{E, 1'h1, 32'h0300, 4'h8}, '{E, 1'h1, 32'h0700, 4'h0}, '{E, 1'h1, 32'h1300, 4'h1},
    '{D, 1'h1, 32'h0300, 4'h0}, '{D, 1'h0, 32'h000d_0000, 4'h0}};
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [REG_AW-1:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic host_valid_in = 1'b0;
  logic host_is_io_in = 1'b0;
  logic [31:0] host_addr_in = '0;
  logic [NUM_DMA_CH-1:0] dma_req_in = '0;
  logic isa_fwd_out, alias_hit_out, dma_block_hit_out, pci_region_out, card_claim, io_q;
  logic [2:0] dma_block_ch_out;
  logic [NUM_DMA_CH-1:0] dma_service_out;
  logic [15:0] addr_q;
  logic [31:0] rdv;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  isa_window_alias_decoder dut_u (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .host_valid_in(host_valid_in), .host_is_io_in(host_is_io_in), .host_addr_in(host_addr_in),
    .dma_req_in(dma_req_in), .isa_fwd_out(isa_fwd_out), .alias_hit_out(alias_hit_out),
    .dma_block_hit_out(dma_block_hit_out), .dma_block_ch_out(dma_block_ch_out),
    .pci_region_out(pci_region_out), .dma_service_out(dma_service_out));
  legacy_card_model card_u (.fwd_in(isa_fwd_out), .io_in(io_q), .addr_in(addr_q), .claim_out(card_claim));
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  // The card sees the address of the cycle that the bridge forwarded one clock later
  always @(posedge clock_in) begin
    addr_q <= host_addr_in[15:0];
    io_q <= host_is_io_in;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic ok, input string msg);
    num_checks = num_checks + 1;
    if (!ok) begin
      fails = fails + 1;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic host(input logic io, input logic [31:0] a);
    @(posedge clock_in);
    host_valid_in <= 1'b1;
    host_is_io_in <= io;
    host_addr_in <= a;
    @(posedge clock_in);
    host_valid_in <= 1'b0;
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    #1 chk({isa_fwd_out, alias_hit_out, dma_block_hit_out, dma_block_ch_out, pci_region_out, dma_service_out,
      reg_rdata_out} === '0, "outputs during reset");
    rd(REG_CTRL, rdv);
    chk(rdv === CTRL_RESET, "ctrl reset");
    rd(REG_DMA_EN, rdv);
    chk(rdv === 32'h0, "dma enable reset");
    rd(8'hfc, rdv);
    chk(rdv === 32'h0, "unmapped read");
    wr(REG_IO_BASE0, 32'h0300);
    wr(REG_IO_LIM0, 32'h031f);
    wr(REG_MEM_BASE0, 32'h000d_0000);
    wr(REG_MEM_LIM0, 32'h000d_ffff);
    wr(REG_DMA_EN, 32'h00ff);
    rd(REG_DMA_EN, rdv);
    chk(rdv === 32'h00ef, "channel without block");
    wr(REG_DMA_EN, 32'h0027);
    foreach (rows[i]) begin
      wr(REG_CTRL, rows[i].ctl);
      host(rows[i].io, rows[i].a);
      chk({isa_fwd_out, alias_hit_out, dma_block_hit_out, pci_region_out} === rows[i].e, "decode");
      chk(card_claim === (rows[i].io & rows[i].e[3]), "card claim");
      if (rows[i].io) chk(dma_block_ch_out === rows[i].a[10:8], "channel number");
    end
    wr(REG_CTRL, A);
    // Status is read while the decode of the aliased cycle still stands
    @(posedge clock_in);
    host_valid_in <= 1'b1;
    host_is_io_in <= 1'b1;
    host_addr_in <= 32'h0700;
    @(posedge clock_in);
    host_valid_in <= 1'b0;
    reg_addr_in <= REG_STATUS;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out === 32'h5, "status copy");
    @(posedge clock_in);
    dma_req_in <= 8'hff;
    #1 chk(reg_rdata_out === 32'h0, "read data one cycle");
    @(posedge clock_in);
    dma_req_in <= 8'hd8;
    #1 chk(dma_service_out === 8'h27, "dma gating");
    // Second reset mid-run must restore alias decoding and clear enables
    @(posedge clock_in);
    rst_in <= 1'b1;
    dma_req_in <= 8'hff;
    #1 chk(dma_service_out === 8'h00, "dma disabled channels");
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1 chk(dma_service_out === 8'h00, "dma after reset");
    rd(REG_CTRL, rdv);
    chk(rdv === CTRL_RESET, "ctrl after reset");
    host(1'b1, 32'h0300);
    chk(isa_fwd_out === 1'b0, "windows off after reset");
    end_of_test();
  end
endmodule // isa_window_alias_decoder_tb
`default_nettype wire
